// ---- rtl/seb_cycle_timer.sv ----
// Self-timed program cycle timer for the serial EEPROM block.
// Assumes start_i is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
module seb_cycle_timer #(
    parameter int CYCLES = seb_pkg::WR_CYCLES                     // Cycle length in clocks
) (
    input  wire logic clk_i,                                      // System clock
    input  wire logic rst_n_i,                                    // Synchronous reset, active low
    input  wire logic start_i,                                    // Begin a cycle
    output logic      busy_o,                                     // Cycle running
    output logic      done_o                                      // High for the one clock after a cycle ends
);
    import seb_pkg::*;

    logic [CNT_W-1:0] cnt_r;                                      // Clocks left

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Countdown, runs on the system clock alone
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_r  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin                               // Load fresh count
            cnt_r  <= CYCLES[CNT_W-1:0];
            busy_o <= 1'b1;
            done_o <= 1'b0;
        end else if (busy_o && cnt_r == CNT_W'(1)) begin          // Final clock
            cnt_r  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b1;
        end else begin
            cnt_r  <= busy_o ? cnt_r - CNT_W'(1) : cnt_r;
            done_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_timer_ends_cycle: assert property (busy_o && cnt_r == CNT_W'(1) && !start_i |=> done_o && !busy_o)
        else $error("cycle timer did not finish");
    a_timer_done_once: assert property (done_o |=> !done_o)
        else $error("done lasted more than one clock");

endmodule

// ---- rtl/seb_eeprom_core.sv ----
// Command execution for a three-wire serial EEPROM: single-word clear,
// whole-array clear and whole-array write, with a write lock.
// Assumes select, serial clock and data in arrive asynchronously from pins.
`timescale 1ns/100ps

// Notes on behaviour
// - Select fall starts clear of addressed word
// - Started cycle finishes without serial clocks
// - Status appears on data out while selected
// - Cleared word reads all ones
// - Select fall starts clear of whole array
// - After array clear every bit is one
// - Select fall stores data word everywhere
// - Array write needs no prior clear
// - Start bit, opcode, address, data format
// - Data out low busy, high ready
// - Locked at reset; unlock enables, lock disables
module seb_eeprom_core #(
    parameter int WR_CYCLES = seb_pkg::WR_CYCLES                  // Self-timed cycle length in clocks
) (
    input  wire logic                       CLOCK_I,              // System clock
    input  wire logic                       RST_N_I,              // Synchronous reset, active low
    input  wire logic                       CHIP_SELECT_I,        // Select pin, active high
    input  wire logic                       SERIAL_CLOCK_I,       // Serial clock pin
    input  wire logic                       SERIAL_IN_PIN_I,      // Serial data in pin
    input  wire logic [seb_pkg::ADDR_W-1:0] READ_ADDR_I,          // Array read index
    output logic      [seb_pkg::DATA_W-1:0] READ_DATA_O,          // Array read data
    output logic                            SERIAL_DATA_O,        // Data out level
    output logic                            SERIAL_DATA_OE_O,     // Data out driven
    output logic                            BUSY_O                // Self-timed cycle running
);
    import seb_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0]        cs_sync_r;                                 // Select synchroniser
    logic [1:0]        sclk_sync_r;                               // Serial clock synchroniser
    logic [1:0]        sdi_sync_r;                                // Data in synchroniser
    logic              cs_prev_r;                                 // Select, one clock late
    logic              sclk_prev_r;                               // Serial clock, one clock late
    logic              cs_s;                                      // Settled select
    logic              sdi_s;                                     // Settled data in
    logic              sclk_rise;                                 // Serial clock rising
    logic              cs_fall;                                   // Select falling
    seb_state_type     state_r;                                   // Sequencer state
    seb_state_type     state_nxt;                                 // Sequencer next state
    logic [4:0]        bit_cnt_r;                                 // Bits after start bit
    logic [4:0]        bit_cnt_nxt;                               // Bit count after this edge
    logic [25:0]       shift_r;                                   // Instruction shift register
    logic [25:0]       shift_nxt;                                 // Shift register with new bit
    seb_op_type        op_r;                                      // Pending operation
    logic [ADDR_W-1:0] addr_r;                                    // Pending address
    logic [DATA_W-1:0] data_r;                                    // Pending data word
    logic              wen_r;                                     // Write unlock flag
    logic              status_r;                                  // Status shown on data out
    logic              start;                                     // Cycle launch
    logic              t_busy;                                    // Timer running
    logic              t_done;                                    // Timer finished
    logic [DATA_W-1:0] mem_r [DEPTH];                             // Array storage

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            cs_sync_r <= 2'h0;
            sclk_sync_r <= 2'h0;
            sdi_sync_r  <= 2'h0;
            cs_prev_r   <= 1'b0;
            sclk_prev_r <= 1'b0;
        end else begin
            cs_sync_r   <= {cs_sync_r[0], CHIP_SELECT_I};
            sclk_sync_r <= {sclk_sync_r[0], SERIAL_CLOCK_I};
            sdi_sync_r  <= {sdi_sync_r[0], SERIAL_IN_PIN_I};
            cs_prev_r   <= cs_sync_r[1];
            sclk_prev_r <= sclk_sync_r[1];
        end
    end

    assign cs_s      = cs_sync_r[1];
    assign sdi_s     = sdi_sync_r[1];
    assign sclk_rise = cs_s && sclk_sync_r[1] && !sclk_prev_r;    // Sampled only while selected
    assign cs_fall   = cs_prev_r && !cs_s;

    // Launch on select fall, only when unlocked and complete
    assign start = (state_r == ST_ARMED) && cs_fall && wen_r && (op_r != OP_NONE);

    // ------------------------------------------------------------
    // Instruction bit counting
    // ------------------------------------------------------------
    assign bit_cnt_nxt = bit_cnt_r + 5'h01;
    assign shift_nxt   = {shift_r[24:0], sdi_s};

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (sclk_rise && sdi_s && !status_r) begin        // Start bit
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (!cs_s) begin                                  // Aborted instruction
                    state_nxt = ST_IDLE;
                end else if (sclk_rise && bit_cnt_nxt == HDR_BITS) begin
                    if (!(shift_nxt[9:8] == OPC_EXT && shift_nxt[7:6] == EXT_FILL)) begin
                        state_nxt = ST_ARMED;                     // Header-only instruction
                    end
                end else if (sclk_rise && bit_cnt_nxt == FILL_BITS) begin
                    state_nxt = ST_ARMED;                         // Data word complete
                end
            end
            ST_ARMED: begin
                if (start) begin
                    state_nxt = ST_BUSY;
                end else if (!cs_s) begin
                    state_nxt = ST_IDLE;                          // Locked or inert instruction
                end
            end
            ST_BUSY: begin
                if (t_done) begin                                 // Only the timer ends it
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer state register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Shift register and bit counter
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            shift_r   <= '0;
            bit_cnt_r <= 5'h00;
        end else if (state_r == ST_IDLE) begin
            bit_cnt_r <= 5'h00;
        end else if (state_r == ST_SHIFT && sclk_rise) begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Instruction decode into pending operation
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            op_r   <= OP_NONE;
            addr_r <= '0;
            data_r <= '0;
        end else if (state_r == ST_SHIFT && sclk_rise && bit_cnt_nxt == HDR_BITS) begin
            addr_r <= shift_nxt[7:0];
            if (shift_nxt[9:8] == OPC_ERASE) begin
                op_r <= OP_ERASE;                                 // Addressed clear
            end else if (shift_nxt[9:8] == OPC_EXT && shift_nxt[7:6] == EXT_WIPE) begin
                op_r <= OP_WIPE;                                  // Whole-array clear
            end else begin
                op_r <= OP_NONE;                                  // Lock, unlock, others
            end
        end else if (state_r == ST_SHIFT && sclk_rise && bit_cnt_nxt == FILL_BITS) begin
            op_r   <= OP_FILL;                                    // Whole-array write
            data_r <= shift_nxt[15:0];
        end
    end

    // ------------------------------------------------------------
    // Write lock flag, cleared by reset
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            wen_r <= 1'b0;                                        // Power-up locked
        end else if (state_r == ST_SHIFT && sclk_rise && bit_cnt_nxt == HDR_BITS
                     && shift_nxt[9:8] == OPC_EXT) begin
            if (shift_nxt[7:6] == EXT_WEN) begin
                wen_r <= 1'b1;                                    // Unlock
            end else if (shift_nxt[7:6] == EXT_WDS) begin
                wen_r <= 1'b0;                                    // Lock
            end
        end
    end

    // ------------------------------------------------------------
    // Status mode: set at launch, dropped by a dummy one when ready
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            status_r <= 1'b0;
        end else if (start) begin
            status_r <= 1'b1;
        end else if (state_r != ST_BUSY && sclk_rise && sdi_s) begin
            status_r <= 1'b0;                                     // Back to high impedance
        end
    end

    // ------------------------------------------------------------
    // Data out pin and busy flag, all registered
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            SERIAL_DATA_O    <= 1'b0;
            SERIAL_DATA_OE_O <= 1'b0;
            BUSY_O           <= 1'b0;
        end else begin
            SERIAL_DATA_O    <= (state_r != ST_BUSY);             // Low busy, high ready
            SERIAL_DATA_OE_O <= cs_s && status_r;                 // Driven while selected
            BUSY_O           <= (state_r == ST_BUSY);
        end
    end

    // ------------------------------------------------------------
    // Self-timed cycle timer
    // ------------------------------------------------------------
    seb_cycle_timer #(
        .CYCLES  (WR_CYCLES)
    ) u_timer (
        .clk_i   (CLOCK_I),
        .rst_n_i (RST_N_I),
        .start_i (start),
        .busy_o  (t_busy),
        .done_o  (t_done)
    );

    // ------------------------------------------------------------
    // Array storage, one update path per word
    // ------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        always_ff @(posedge CLOCK_I) begin
            if (t_done && state_r == ST_BUSY) begin
                if (op_r == OP_WIPE || (op_r == OP_ERASE && addr_r == ADDR_W'(i))) begin
                    mem_r[i] <= ERASED_WORD;
                end else if (op_r == OP_FILL) begin
                    mem_r[i] <= data_r;                           // Overwrites directly
                end
            end
        end
    end

    // Read port for the array
    always_ff @(posedge CLOCK_I) begin
        READ_DATA_O <= mem_r[READ_ADDR_I];
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_start_needs_unlock: assert property (start |-> wen_r && cs_fall)
        else $error("cycle launched while locked or without select fall");
    a_launch_enters_busy: assert property (start |=> state_r == ST_BUSY && t_busy)
        else $error("launch did not start the timer");
    a_busy_ignores_input: assert property (state_r == ST_BUSY && !t_done |=> state_r == ST_BUSY)
        else $error("busy cycle left early");
    a_busy_tracks_timer: assert property (state_r == ST_BUSY |-> t_busy || t_done)
        else $error("busy without running timer");
    a_erase_one_word: assert property (t_done && op_r == OP_ERASE |=> mem_r[$past(addr_r)] == ERASED_WORD)
        else $error("addressed word not cleared");
    a_wipe_all_ones: assert property (t_done && op_r == OP_WIPE
                                      |=> mem_r[0] == ERASED_WORD && mem_r[DEPTH-1] == ERASED_WORD)
        else $error("array clear left zero bits");
    a_fill_stores_all: assert property (t_done && op_r == OP_FILL
                                        |=> mem_r[0] == $past(data_r) && mem_r[DEPTH-1] == $past(data_r))
        else $error("array write missed a word");
    a_status_busy_low: assert property (cs_s && status_r && state_r == ST_BUSY
                                        |=> SERIAL_DATA_OE_O && !SERIAL_DATA_O)
        else $error("busy status not low on data out");
    a_status_ready_high: assert property (cs_s && status_r && state_r == ST_IDLE
                                          |=> SERIAL_DATA_OE_O && SERIAL_DATA_O)
        else $error("ready status not high on data out");
    a_lock_blocks_cycle: assert property (state_r == ST_ARMED && cs_fall && !wen_r |=> state_r == ST_IDLE)
        else $error("locked instruction was executed");

    c_erase_done: cover property (t_done && op_r == OP_ERASE);
    c_wipe_done:  cover property (t_done && op_r == OP_WIPE);
    c_fill_done:  cover property (t_done && op_r == OP_FILL);
    c_ready_seen: cover property (SERIAL_DATA_OE_O && SERIAL_DATA_O);

endmodule

// ---- shared/seb_pkg.sv ----
// Constants and types for the serial EEPROM erase and bulk write block.
// Assumes a single 25 MHz system clock and the x16 array organisation.
package seb_pkg;

    // ------------------------------------------------------------
    // Clock and self-timed cycle
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 25_000_000;                     // System clock rate
    localparam int WR_TIME_US   = 5000;                           // Self-timed cycle length, microseconds
    localparam int WR_CYCLES    = WR_TIME_US * (CLK_HZ / 1_000_000); // Cycle length in clocks
    localparam int CNT_W        = 24;                             // Cycle timer width

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W       = 8;                              // Word address width
    localparam int DATA_W       = 16;                             // Word width
    localparam int DEPTH        = 256;                            // Number of words
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;         // Cleared word value

    // ------------------------------------------------------------
    // Instruction format
    // ------------------------------------------------------------
    localparam logic [4:0] HDR_BITS  = 5'h0a;                     // Opcode plus address bits
    localparam logic [4:0] FILL_BITS = 5'h1a;                     // Header plus data bits
    localparam logic [1:0] OPC_ERASE = 2'h3;                      // Single-word clear
    localparam logic [1:0] OPC_EXT   = 2'h0;                      // Extended group
    localparam logic [1:0] EXT_WIPE  = 2'h2;                      // Clear whole array
    localparam logic [1:0] EXT_FILL  = 2'h1;                      // Write whole array
    localparam logic [1:0] EXT_WEN   = 2'h3;                      // Write unlock
    localparam logic [1:0] EXT_WDS   = 2'h0;                      // Write lock

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,                                       // Waiting for start bit
        ST_SHIFT = 4'b0010,                                       // Shifting instruction
        ST_ARMED = 4'b0100,                                       // Complete, waiting select fall
        ST_BUSY  = 4'b1000                                        // Self-timed cycle running
    } seb_state_type;

    typedef enum logic [1:0] {
        OP_NONE  = 2'h0,                                          // Nothing to run
        OP_ERASE = 2'h1,                                          // Clear one word
        OP_WIPE  = 2'h2,                                          // Clear all words
        OP_FILL  = 2'h3                                           // Store one word everywhere
    } seb_op_type;

endpackage

// ---- verification/seb_host_model.sv ----
// Host model driving the three-wire serial bus of the EEPROM block.
// Assumes the device synchronises the pins; all edges are spaced in system clocks.
`timescale 1ns/100ps
module seb_host_model (
    input  wire logic clk_i,  // System clock
    input  wire logic data_i, // Device data out
    input  wire logic oe_i,   // Device data out driven
    output logic      cs_o,   // Select
    output logic      sclk_o, // Serial clock, still outside frames
    output logic      sdi_o   // Serial data in
);
    initial begin
        cs_o   = 1'b0;
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
    end
    // One serial clock pulse, five system clocks per phase
    task automatic pulse();
        repeat (5) @(posedge clk_i);
        sclk_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        sclk_o <= 1'b0;
    endtask
    // Shift n bits MSB first, then drop select
    task automatic send(input logic [26:0] v, input int n);
        @(posedge clk_i) cs_o <= 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_i) sdi_o <= v[i];
            pulse();
        end
        repeat (5) @(posedge clk_i);
        cs_o  <= 1'b0;
        sdi_o <= ~sdi_o; // Data in parked at the other level
        repeat (8) @(posedge clk_i);
    endtask
    // Select again and wait, serial clock idle, for ready on data out
    task automatic poll(output logic [1:0] first, output int waited);
        @(posedge clk_i) cs_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        // Status is looked at mid-cycle, where the registered pins are settled
        @(negedge clk_i);
        first = {oe_i, data_i};
        waited = 0;
        while (!(oe_i === 1'b1 && data_i === 1'b1) && waited < 1000) begin
            @(negedge clk_i);
            waited++;
        end
        @(posedge clk_i);
        sdi_o <= 1'b1; // Dummy one leaves status mode
        pulse();
        cs_o  <= 1'b0;
        sdi_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ---- verification/tb_serial_eeprom_erase_and_bulk_write.sv ----
// Self-checking bench for the erase and bulk write block.
// Assumes a shortened self-timed cycle; the host model drives the serial pins.
`timescale 1ns/100ps
module tb_serial_eeprom_erase_and_bulk_write;
    import seb_pkg::*;
    localparam int WRC = 400;        // Shortened cycle length
    logic              clock = 1'b0; // System clock
    logic              rst_n = 1'b0; // Reset, active low
    logic              cs, sclk, sdi; // Serial pins
    logic [ADDR_W-1:0] raddr = '0;   // Read index
    logic [DATA_W-1:0] rdata;        // Read word
    logic              sdo, sdo_oe, busy;
    int                miscompares = 0, check_count = 0, cycles = 0;
    always #20 clock = ~clock;
    seb_eeprom_core #(.WR_CYCLES(WRC)) i_seb_eeprom_core (.CLOCK_I(clock), .RST_N_I(rst_n),
        .CHIP_SELECT_I(cs), .SERIAL_CLOCK_I(sclk), .SERIAL_IN_PIN_I(sdi), .READ_ADDR_I(raddr),
        .READ_DATA_O(rdata), .SERIAL_DATA_O(sdo), .SERIAL_DATA_OE_O(sdo_oe), .BUSY_O(busy));
    seb_host_model i_seb_host_model (.clk_i(clock), .data_i(sdo), .oe_i(sdo_oe), .cs_o(cs),
        .sclk_o(sclk), .sdi_o(sdi));
    task automatic final_report();
        if (miscompares == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-bit results: busy level, cycle length in range
    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t flag got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Status pins as {driven, level}
    task automatic chk_stat(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t status got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Instruction word: start bit, opcode, address, data
    function automatic logic [26:0] ins(input logic [1:0] opc, input logic [7:0] a, input logic [15:0] d);
        return {1'b1, opc, a, d};
    endfunction
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clock) raddr <= a;
        repeat (2) @(posedge clock);
        chk(rdata, exp);
    endtask
    // Corner and random locations
    task automatic words(input logic [DATA_W-1:0] exp);
        rd(8'h00, exp);
        rd(8'hff, exp);
        rd(8'($urandom), exp);
    endtask
    task automatic op(input logic [26:0] v, input int n, input logic launch);
        logic [1:0] st;
        int         w;
        i_seb_host_model.send(v, n);
        if (launch) begin
            i_seb_host_model.poll(st, w);
            chk_stat(st, 2'b10);
            chk_flag(w > WRC - 40 && w < WRC + 10, 1'b1);
        end else begin
            chk_flag(busy, 1'b0);
        end
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        logic [15:0] d0, d1;
        logic [7:0]  ea;
        logic [1:0]  st;
        int          w;
        void'($urandom(71));
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        d0 = 16'($urandom);
        d1 = ~d0;
        ea = 8'($urandom);
        op(ins(OPC_EXT, {EXT_FILL, 6'($urandom)}, d0), 27, 1'b0);
        op(ins(OPC_EXT, {EXT_WEN, 6'($urandom)}, 16'h0000) >> 16, 11, 1'b0);
        op(ins(OPC_EXT, {EXT_FILL, 6'($urandom)}, d0), 27, 1'b1);
        words(d0);
        i_seb_host_model.send(ins(OPC_ERASE, ea, 16'h0000) >> 16, 11);
        i_seb_host_model.send(ins(OPC_EXT, {EXT_FILL, 6'h00}, d1), 27);
        i_seb_host_model.poll(st, w);
        chk_stat(st, 2'b10);
        rd(ea, ERASED_WORD);
        rd(ea + 8'h01, d0);
        op(ins(OPC_EXT, {EXT_WIPE, 6'($urandom)}, 16'h0000) >> 16, 11, 1'b1);
        words(ERASED_WORD);
        // Select dropped one data bit short: nothing may be launched or stored
        op(ins(OPC_EXT, {EXT_FILL, 6'h00}, d1) >> 1, 26, 1'b0);
        rd(ea, ERASED_WORD);
        op(ins(OPC_EXT, {EXT_FILL, 6'($urandom)}, d1), 27, 1'b1);
        op(ins(OPC_EXT, {EXT_WDS, 6'($urandom)}, 16'h0000) >> 16, 11, 1'b0);
        op(ins(OPC_EXT, {EXT_WIPE, 6'($urandom)}, 16'h0000) >> 16, 11, 1'b0);
        words(d1);
        final_report();
    end
endmodule
